// ---- hw/asrc_pkg.sv ----
// Package: constants, types and timing for the async SRAM requester
package asrc_pkg;

  // Geometry
  localparam int unsigned WORD_SELECT_W = 17;      // Word-select width
  localparam int unsigned BYTE_W        = 8;       // Byte lane width
  localparam int unsigned DEPTH         = 131072;  // Locations

  // Clock
  localparam int unsigned CLK_PERIOD_PS = 5000;    // 200 MHz

  // Timing figures in ns (recovery in ms), as printed
  localparam int unsigned CYCLE_MIN_NS     = 70;   // Least access spacing
  localparam int unsigned ACCESS_MAX_NS    = 70;   // Address/select access
  localparam int unsigned GATE_ACCESS_NS   = 35;   // Output gate access
  localparam int unsigned STROBE_MIN_NS    = 50;   // Write strobe width
  localparam int unsigned SELECT_MIN_NS    = 60;   // Select to end of write
  localparam int unsigned DATA_SETUP_NS    = 30;   // Data before end of write
  localparam int unsigned FLOAT_MAX_NS     = 25;   // Device release time
  localparam int unsigned RECOVERY_MS      = 5;    // After supply return

  // Cycle counts, least times rounded up
  localparam int unsigned CYCLE_CYC  = (CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACCESS_CYC = (ACCESS_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GATE_CYC   = (GATE_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SELECT_CYC = (SELECT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETUP_CYC  = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FLOAT_CYC  = (FLOAT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned RECOVERY_CYC_DEF =
    (64'(RECOVERY_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS);

  // Counter width
  localparam int unsigned CNT_W = 8;
  localparam int unsigned REC_W = 24;

  // Reset values of pins
  localparam logic RST_SELECT_LOW  = 1'b1;         // Deselected
  localparam logic RST_SELECT_HIGH = 1'b0;         // Deselected
  localparam logic RST_GATE_N      = 1'b1;         // Output gate off
  localparam logic RST_STROBE      = 1'b1;         // Read level

  // Request from user side
  typedef struct packed {
    logic                     write;
    logic [WORD_SELECT_W-1:0] wordSelect;
    logic [BYTE_W-1:0]        data;
  } asrc_req_t;

  // Control pins to the memory
  typedef struct packed {
    logic                     selectActiveLow_n;
    logic                     selectActiveHigh;
    logic                     outputGate_n;
    logic                     readWrite;
    logic [WORD_SELECT_W-1:0] wordSelect;
  } asrc_pins_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RECOVER,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_SPACE,
    ST_RETAIN
  } asrc_state_t;

endpackage : asrc_pkg

// ---- hw/asrc_requester.sv ----
// Requester that drives an asynchronous 128K x 8 static memory
//
// Behaviour
// - Read keeps strobe high, gate low
// - Write uses both selects and strobe low
// - Strobe 50, select 60, data 30 ns
// - Accesses start no closer than 70 ns
// - Never drive against device outputs
// - Deselect for retention; wait 5 ms after
`timescale 1ns/100ps
module asrc_requester #(
  parameter longint unsigned RECOVERY_CYC = asrc_pkg::RECOVERY_CYC_DEF  // Shorten in sim
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // User request side
  input  wire logic                              reqValid,
  output logic                                   reqReady,
  input  wire asrc_pkg::asrc_req_t               req,
  output logic                                   rspValid,
  output logic [asrc_pkg::BYTE_W-1:0]            rspData,
  // Retention control
  input  wire logic                              retainReq,
  input  wire logic                              supplyGood,
  output logic                                   retaining,
  // Memory control pins
  output asrc_pkg::asrc_pins_t                   pins,
  // Byte lines, split three ways
  input  wire logic [asrc_pkg::BYTE_W-1:0]       byteLinesIn,
  output logic      [asrc_pkg::BYTE_W-1:0]       byteLinesOut,
  output logic                                   byteLinesOe
);

  ////////////////////////////////////////////////////////////////////////////
  // State and counters
  asrc_pkg::asrc_state_t             state;       // Sequencer state
  asrc_pkg::asrc_state_t             next_state;  // Next sequencer state
  logic [asrc_pkg::CNT_W-1:0]        cnt;         // Cycles in phase
  logic [asrc_pkg::REC_W-1:0]        recCnt;      // Recovery wait
  asrc_pkg::asrc_req_t               held;        // Latched request
  logic [asrc_pkg::BYTE_W-1:0]       syncData;    // Synchronised byte lines
  logic                              supplySync;  // Synchronised supply flag

  ////////////////////////////////////////////////////////////////////////////
  // Phase ends as named wires
  wire readDone   = (cnt == asrc_pkg::CNT_W'(asrc_pkg::ACCESS_CYC + 4));  // Access plus sync
  wire writeHold  = (cnt >= asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC));       // Device released
  wire writeDone  = (cnt == asrc_pkg::CNT_W'(asrc_pkg::SELECT_CYC));      // Select width met
  wire strobeLow  = (cnt <  asrc_pkg::CNT_W'(asrc_pkg::SELECT_CYC));      // Strobe window
  wire spaceDone  = (cnt >= asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC));       // Bus turnaround
  wire recDone    = (recCnt >= asrc_pkg::REC_W'(RECOVERY_CYC));           // Recovery over
  wire inRead     = (state == asrc_pkg::ST_READ);
  wire inWrite    = (state == asrc_pkg::ST_WRITE);
  wire selected   = inRead || inWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs (byte lines and supply flag)
  asrc_sync3 #(
    .W (asrc_pkg::BYTE_W + 1)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({supplyGood, byteLinesIn}),
    .syncOut ({supplySync, syncData})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_state = state;
    case (state)
      // Wait out recovery after power-up or retention
      asrc_pkg::ST_RECOVER:
        if (recDone && supplySync)
          next_state = asrc_pkg::ST_IDLE;
      // Take one request at a time
      asrc_pkg::ST_IDLE:
        if (retainReq)
          next_state = asrc_pkg::ST_RETAIN;
        else if (reqValid)
          next_state = req.write ? asrc_pkg::ST_WRITE : asrc_pkg::ST_READ;
      // Read: hold until data sampled
      asrc_pkg::ST_READ:
        if (readDone)
          next_state = asrc_pkg::ST_SPACE;
      // Write: end by strobe rise, selects still asserted
      asrc_pkg::ST_WRITE:
        if (writeDone)
          next_state = asrc_pkg::ST_SPACE;
      // Turnaround keeps spacing
      asrc_pkg::ST_SPACE:
        if (spaceDone)
          next_state = asrc_pkg::ST_IDLE;
      // Stay deselected until released
      asrc_pkg::ST_RETAIN:
        if (!retainReq)
          next_state = asrc_pkg::ST_RECOVER;
      default:
        next_state = asrc_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and phase counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= asrc_pkg::ST_RECOVER;
      cnt   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recovery counter, cleared while supply low or retaining
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      recCnt <= '0;
    else if (state != asrc_pkg::ST_RECOVER || !supplySync)
      recCnt <= '0;
    else if (!recDone)
      recCnt <= recCnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch request on acceptance, stable for whole access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      held <= '0;
    else if (reqValid && reqReady)
      held <= req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pins from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins.selectActiveLow_n <= asrc_pkg::RST_SELECT_LOW;
      pins.selectActiveHigh  <= asrc_pkg::RST_SELECT_HIGH;
      pins.outputGate_n      <= asrc_pkg::RST_GATE_N;
      pins.readWrite         <= asrc_pkg::RST_STROBE;
      pins.wordSelect        <= '0;
    end
    else
    begin
      // Both selects asserted only during an access
      pins.selectActiveLow_n <= !(next_state == asrc_pkg::ST_READ ||
                                  next_state == asrc_pkg::ST_WRITE);
      pins.selectActiveHigh  <= (next_state == asrc_pkg::ST_READ ||
                                 next_state == asrc_pkg::ST_WRITE);
      // Gate low only for reads; high in writes floats device
      pins.outputGate_n      <= !(next_state == asrc_pkg::ST_READ);
      // Strobe low from select onward, low select and strobe fall together
      pins.readWrite         <= !(next_state == asrc_pkg::ST_WRITE &&
                                  (state != asrc_pkg::ST_WRITE || cnt + 1'b1 <
                                   asrc_pkg::CNT_W'(asrc_pkg::SELECT_CYC)));
      if (reqValid && reqReady)
        pins.wordSelect <= req.wordSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte line drive: only after device release, never in reads
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      byteLinesOe  <= 1'b0;
      byteLinesOut <= '0;
    end
    else
    begin
      byteLinesOe  <= inWrite && writeHold && strobeLow;
      byteLinesOut <= held.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data capture
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end
    else
    begin
      rspValid <= inRead && readDone;
      if (inRead && readDone)
        rspData <= syncData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and status
  assign reqReady  = (state == asrc_pkg::ST_IDLE) && !retainReq;
  assign retaining = (state == asrc_pkg::ST_RETAIN);

endmodule : asrc_requester

// ---- hw/asrc_sync3.sv ----
// Three-stage synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
module asrc_sync3 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////////
  logic [W-1:0] stage1;   // Metastable catch, read by stage2 only
  logic [W-1:0] stage2;   // Second stage
  logic [W-1:0] stage3;   // Third stage

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Per-bit shift and agreement filter
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          stage1[i]  <= 1'b0;
          stage2[i]  <= 1'b0;
          stage3[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= asyncIn[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i])
            syncOut[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule : asrc_sync3

// ---- verification/asrc_requester_assertions.sv ----
// Checker for the requester's memory-side timing
`timescale 1ns/100ps
module asrc_requester_assertions #(
  parameter longint unsigned RECOVERY_CYC = 8  // Recovery wait
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // User side
  input wire logic                 reqValid,
  input wire logic                 reqReady,
  input wire asrc_pkg::asrc_req_t  req,
  input wire logic                 rspValid,
  input wire logic [7:0]           rspData,
  input wire logic                 retainReq,
  input wire logic                 supplyGood,
  input wire logic                 retaining,
  // Memory side
  input wire asrc_pkg::asrc_pins_t pins,
  input wire logic [7:0]           byteLinesIn,
  input wire logic [7:0]           byteLinesOut,
  input wire logic                 byteLinesOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  wire        sel = !pins.selectActiveLow_n && pins.selectActiveHigh;  // Both on
  logic       selPrev;   // Select last cycle
  logic [7:0] selCnt;    // Cycles selected
  logic [7:0] gapCnt;    // Cycles since access start
  logic [7:0] dataCnt;   // Cycles write data held
  logic [7:0] lastData;  // Write data last cycle
  logic [7:0] lowCnt;    // Cycles strobe low
  // Run lengths behind the write and spacing checks
  always_ff @(posedge clk)
  begin
    selPrev  <= sel;
    lastData <= byteLinesOut;
    selCnt   <= sel ? selCnt + 8'h01 : 8'h00;
    lowCnt   <= pins.readWrite ? 8'h00 : lowCnt + 8'h01;
    dataCnt  <= !byteLinesOe ? 8'h00 : (byteLinesOut != lastData) ? 8'h01 : dataCnt + 8'h01;
    if (!rst_n)
      gapCnt <= 8'hff;
    else if (sel && !selPrev)
      gapCnt <= 8'h01;
    else if (gapCnt != 8'hff)
      gapCnt <= gapCnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  read_strobe_high_a: assert property (sel && !pins.outputGate_n |-> pins.readWrite)
    else $error("gate open with strobe low");
  strobe_width_a: assert property (sel && $rose(pins.readWrite) |-> lowCnt >= 8'h0a)
    else $error("write strobe too short");
  select_width_a: assert property (sel && $rose(pins.readWrite) |-> selCnt >= 8'h0c)
    else $error("select too short before write end");
  data_setup_a: assert property (sel && $rose(pins.readWrite) |-> dataCnt >= 8'h06)
    else $error("write data setup too short");
  access_space_a: assert property ($rose(sel) |-> gapCnt >= 8'h0e)
    else $error("accesses too close");
  no_contention_a: assert property ($fell(pins.readWrite) |-> !byteLinesOe [*5])
    else $error("drove lines during release");
  retain_desel_a: assert property (retaining |-> !sel && !reqReady)
    else $error("selected during retention");
  word_stable_a: assert property (sel && $past(sel) |-> $stable(pins.wordSelect))
    else $error("word select moved in access");
endmodule : asrc_requester_assertions

bind asrc_requester asrc_requester_assertions #(.RECOVERY_CYC(RECOVERY_CYC)) chk_i (
  .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady), .req(req),
  .rspValid(rspValid), .rspData(rspData), .retainReq(retainReq), .supplyGood(supplyGood),
  .retaining(retaining), .pins(pins), .byteLinesIn(byteLinesIn),
  .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe));

// ---- verification/asrc_sram_model.sv ----
// Behavioural model of the 128K x 8 asynchronous static memory
`timescale 1ns/100ps
module asrc_sram_model (
  // Control pins
  input  wire asrc_pkg::asrc_pins_t pins,
  // Requester data and enable
  input  wire logic [7:0]           byteLinesOut,
  input  wire logic                 byteLinesOe,
  // Resolved byte line level
  output logic      [7:0]           byteLinesIn
);
  logic [7:0] mem [asrc_pkg::DEPTH];  // One byte per location
  wire sel = !pins.selectActiveLow_n && pins.selectActiveHigh;  // Else standby
  // Drive only in read mode
  wire drive = sel && !pins.outputGate_n && pins.readWrite;
  wire #70 selLate = sel;                      // Select access
  wire #35 gateLate = !pins.outputGate_n;      // Gate access
  wire [16:0] #70 wordLate = pins.wordSelect;  // Address access
  wire valid = selLate && gateLate && wordLate == pins.wordSelect;
  wire [7:0] val = mem[pins.wordSelect];       // Addressed byte
  // Garbage until valid; released lines show the inverse of the requester
  assign byteLinesIn = drive ? (valid ? val : ~val) : byteLinesOe ? byteLinesOut : ~byteLinesOut;
  // Store where the write ends: strobe rise or deselect
  always @(posedge pins.readWrite or negedge sel)
  begin
    if (sel || !pins.readWrite)
      mem[pins.wordSelect] = byteLinesOut;
  end
endmodule : asrc_sram_model

// ---- verification/testbench.sv ----
// Bench for the async memory requester and its memory model
`timescale 1ns/100ps
module testbench;
  localparam longint unsigned REC = 8;  // Shortened recovery
  logic clk = 1'b0;                     // 200 MHz clock
  logic rst_n, reqValid, reqReady, rspValid, retainReq, supplyGood, retaining;
  asrc_pkg::asrc_req_t  req;            // Request
  asrc_pkg::asrc_pins_t pins;           // Control pins
  logic [7:0] rspData, byteLinesIn, byteLinesOut;  // Data paths
  logic byteLinesOe;                    // Requester drives lines
  int failures = 0, num_checks = 0, cycles = 0;  // Tallies
  ////////////////////////////////////////////////////////////
  asrc_requester #(.RECOVERY_CYC(REC)) asrc_requester_i (.clk(clk), .rst_n(rst_n),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
    .rspData(rspData), .retainReq(retainReq), .supplyGood(supplyGood), .retaining(retaining),
    .pins(pins), .byteLinesIn(byteLinesIn), .byteLinesOut(byteLinesOut),
    .byteLinesOe(byteLinesOe));
  asrc_sram_model asrc_sram_model_i (.pins(pins), .byteLinesOut(byteLinesOut),
    .byteLinesOe(byteLinesOe), .byteLinesIn(byteLinesIn));
  // Clock and cycle ceiling
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One request; a read compares the byte returned
  task automatic access(input logic wr, input logic [16:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    reqValid = 1'b1;
    req = '{wr, adr, dat};
    while (reqReady !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    while (!wr && rspValid !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!wr)
    begin
      check("read wait", 32'(n >= 14), 32'h1);
      check("read data", 32'(rspData), 32'(dat));
    end
    @(posedge clk);
    #1;
  endtask : access
  // Pins idle and requests refused just after reset
  task automatic test_reset();
    @(posedge clk);
    #1;
    check("low select", 32'(pins.selectActiveLow_n), 32'h1);
    check("high select", 32'(pins.selectActiveHigh), 32'h0);
    check("drive", 32'(byteLinesOe), 32'h0);
    check("ready", 32'(reqReady), 32'h0);
  endtask : test_reset
  // Back-to-back writes at edge addresses, overwrite, read back
  task automatic test_write_read();
    logic [16:0] adr [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
    logic [7:0]  dat [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
    for (int i = 0; i < 4; i++)
      access(1'b1, adr[i], dat[i]);
    access(1'b1, 17'h00000, 8'h3c);
    access(1'b0, 17'h00000, 8'h3c);
    for (int i = 1; i < 4; i++)
      access(1'b0, adr[i], dat[i]);
  endtask : test_write_read
  // Retention with a write held off, supply dip, recovery wait
  task automatic test_retention();
    int n;
    n = 0;
    retainReq = 1'b1;
    reqValid = 1'b1;
    req = '{1'b1, 17'h00100, 8'hc3};
    while (retaining !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    check("retain select", 32'(pins.selectActiveLow_n), 32'h1);
    check("retain ready", 32'(reqReady), 32'h0);
    supplyGood = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    supplyGood = 1'b1;
    retainReq = 1'b0;
    while (reqReady !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("recovery wait", 32'(n >= REC), 32'h1);
    access(1'b1, 17'h00100, 8'hc3);
    access(1'b0, 17'h1ffff, 8'ha5);
    access(1'b0, 17'h00100, 8'hc3);
  endtask : test_retention
  // Verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    retainReq = 1'b0;
    supplyGood = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_write_read();
    test_retention();
    report_and_stop();
  end
endmodule : testbench
